/* src/cmsc_map.vh */
`ifndef CMSC_MAP_VH
`define CMSC_MAP_VH

// Clock rate in MHz
`define CMSC_CLK_MHZ 20

// Timing figures in ns, soft-start step in clock cycles
`define CMSC_TERM_WIN_NS 300000
`define CMSC_FULL_HOLD_NS 750000
`define CMSC_SOFT_STEP_CYCLES 2000

// Register byte offsets
`define CMSC_REG_CTRL 4'h0
`define CMSC_REG_STATUS 4'h4

// Control fields and reset value
`define CMSC_CTRL_EN_BIT 0
`define CMSC_CTRL_RESET 1'b1

// AXI responses
`define CMSC_RESP_OKAY 2'b00
`define CMSC_RESP_SLVERR 2'b10

// Decoded mode selections
`define CMSC_MODE_LOW 2'b00
`define CMSC_MODE_MID 2'b01
`define CMSC_MODE_HIGH 2'b10

// Current target levels
`define CMSC_LVL_PRE 2'b00
`define CMSC_LVL_20 2'b01
`define CMSC_LVL_60 2'b10
`define CMSC_LVL_100 2'b11

// Synchronised flag positions
`define CMSC_F_BELOW_LOW 0
`define CMSC_F_ABOVE_HIGH 1
`define CMSC_F_UVLO_OK 2
`define CMSC_F_OVP 3
`define CMSC_F_ABOVE_PRE 4
`define CMSC_F_BELOW_RECH 5
`define CMSC_F_ABOVE_TRANS 6
`define CMSC_F_OVER_CURR 7
`define CMSC_F_BELOW_TERM 8
`define CMSC_F_THERMAL 9
`define CMSC_FLAG_W 10

`endif

/* src/cmsc_sync.v */
module cmsc_sync #(
  parameter WIDTH = 1
)(
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  // First stage is read by the second stage only
  reg [WIDTH-1:0] meta;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

/* src/cmsc_term_window.v */
module cmsc_term_window #(
  parameter CNT_W = 16,
  parameter [CNT_W-1:0] WIN_CYCLES = 16'd6000
)(
  input wire aclk,
  input wire aresetn,
  input wire run,
  input wire restart,
  input wire below_term,
  output reg term_done
);
  // Any load peak above the threshold restarts the window, so the peak of
  // the recent past has to stay below termination for the whole window
  reg [CNT_W-1:0] cnt;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= {CNT_W{1'b0}};
      term_done <= 1'b0;
    end else if (!run || restart || !below_term) begin
      cnt <= {CNT_W{1'b0}};
      term_done <= 1'b0;
    end else if (cnt >= WIN_CYCLES - 1'b1) begin
      term_done <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule

/* src/cmsc_top.v */
// Notes on behaviour
// [RULE1] Low selection: charge, then float-charge as voltage regulator after termination.
// [RULE2] Mid selection: charge, then output off and monitor state at termination.
// [RULE3] High selection disables charging entirely.
// [RULE4] Recognised high is latched; float circuit off, input high impedance.
// [RULE5] Host pulls the input to mid or low to leave the latched high.
// [RULE6] Host GPIO drives 0 for low, 1 for high, input for mid.
// [RULE7] Leaving high for mid or low starts a new cycle, status asserted.
// [RULE8] Mid: cycle complete turns output off, releases status, enters monitor.
// [RULE9] Monitor: battery below recharge threshold starts automatic recharge.
// [RULE10] Monitor: low selection leaves monitor and float-charges, output on.
// [RULE11] Back to mid after forced low: charge to termination, then monitor.
// [RULE12] Host should hold low at least 1ms for a reliable forced recharge.
// [RULE13] Forced recharge never changes the status output.
// [RULE14] Forced recharge accepted any time without disturbing operation.
// [RULE15] Status pin only pulls low or is released, never driven high.
// [RULE16] Status asserted as charging begins with input valid, no overvoltage.
// [RULE17] Status released on termination, high selection or input removal.
// [RULE18] Battery already full: status still held asserted about 750us.
// [RULE19] Automatic recharge cycles leave status released.
// [RULE20] Current regulation until output passes the transition threshold.
// [RULE21] Transition threshold sits about 5mV above regulation voltage.
// [RULE22] Voltage regulation reverts to current when current exceeds 105 percent.
// [RULE23] Termination when current plus recent peak load stays below threshold.
// [RULE24] After precharge, soft-start steps 20, 60 then 100 percent.
// [RULE25] Overvoltage halts charging, releases status; restart asserts it again.
// [RULE26] Thermal limiting keeps all functions and the logical state.
// [RULE27] Mode input arrives as two comparator flags decoded to three ranges.
// [RULE28] Reset or no valid input: output off, status released, idle.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`include "cmsc_map.vh"

module cmsc_top #(
  parameter ADDR_W = 4,
  parameter CNT_W = 16,
  parameter TERM_WIN_CYCLES = (`CMSC_TERM_WIN_NS * `CMSC_CLK_MHZ + 999) / 1000,
  parameter FULL_HOLD_CYCLES = (`CMSC_FULL_HOLD_NS * `CMSC_CLK_MHZ + 999) / 1000,
  parameter SOFT_STEP_CYCLES = `CMSC_SOFT_STEP_CYCLES
)(
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  input wire mode_below_low,
  input wire mode_above_high,
  input wire input_uvlo_ok,
  input wire input_ovp,
  input wire bat_above_precharge,
  input wire bat_below_recharge,
  input wire vout_above_transition,
  input wire iout_over_margin,
  input wire iout_below_term,
  input wire thermal_limit,
  output reg charge_output_en,
  output reg cv_regulation,
  output reg [1:0] current_level,
  output reg mode_float_en,
  output reg mode_input_hiz,
  output reg charge_status_n_o,
  output reg charge_status_n_oe_n
);
  localparam ST_IDLE = 3'd0;
  localparam ST_PRE = 3'd1;
  localparam ST_FAST = 3'd2;
  localparam ST_FLOAT = 3'd3;
  localparam ST_MON = 3'd4;
  localparam ST_DIS = 3'd5;

  localparam [CNT_W-1:0] TERM_WIN = TERM_WIN_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] FULL_HOLD = FULL_HOLD_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] SOFT_STEP = SOFT_STEP_CYCLES[CNT_W-1:0];

  function [1:0] decode_mode;
    input below_low;
    input above_high;
    begin
      if (above_high) begin
        decode_mode = `CMSC_MODE_HIGH;
      end else if (below_low) begin
        decode_mode = `CMSC_MODE_LOW;
      end else begin
        decode_mode = `CMSC_MODE_MID;
      end
    end
  endfunction

  function [2:0] cycle_entry;
    input above_pre;
    begin
      cycle_entry = above_pre ? ST_FAST : ST_PRE;
    end
  endfunction

  wire [`CMSC_FLAG_W-1:0] flags_raw;
  wire [`CMSC_FLAG_W-1:0] flags;
  wire term_done;

  reg ctrl_en;
  reg [2:0] state;
  reg [2:0] next_state;
  reg stat_on;
  reg next_stat;
  reg start_cyc;
  reg term_evt;
  reg mode_hold_high;
  reg term_pending;
  reg [CNT_W-1:0] hold_cnt;
  reg [CNT_W-1:0] step_cnt;
  reg [1:0] mode_eff;
  reg input_ok;

  assign flags_raw = {thermal_limit, iout_below_term, iout_over_margin,
                      vout_above_transition, bat_below_recharge, bat_above_precharge,
                      input_ovp, input_uvlo_ok, mode_above_high, mode_below_low};

  // Comparator flags come from the analog side, so they are synchronised first
  cmsc_sync #(
    .WIDTH(`CMSC_FLAG_W)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(flags_raw),
    .sync_out(flags)
  );

  cmsc_term_window #(
    .CNT_W(CNT_W),
    .WIN_CYCLES(TERM_WIN)
  ) u_term (
    .aclk(aclk),
    .aresetn(aresetn),
    .run((state == ST_FAST) || (state == ST_FLOAT)),
    .restart(next_state != state),
    .below_term(flags[`CMSC_F_BELOW_TERM]),
    .term_done(term_done)
  );

  // Effective selection, with a recognised high latched until the pin drops
  always @* begin
    if (mode_hold_high) begin
      mode_eff = `CMSC_MODE_HIGH; // [RULE4]
    end else begin
      mode_eff = decode_mode(flags[`CMSC_F_BELOW_LOW], flags[`CMSC_F_ABOVE_HIGH]); // [RULE27]
    end
    input_ok = flags[`CMSC_F_UVLO_OK] && !flags[`CMSC_F_OVP] && ctrl_en;
  end

  always @* begin
    next_state = state;
    next_stat = stat_on;
    start_cyc = 1'b0;
    term_evt = 1'b0;
    if (!input_ok) begin
      next_state = ST_IDLE; // [RULE28] [RULE25]
      next_stat = 1'b0; // [RULE17]
    end else if (mode_eff == `CMSC_MODE_HIGH) begin
      next_state = ST_DIS; // [RULE3]
      next_stat = 1'b0; // [RULE17]
    end else begin
      case (state)
        ST_IDLE, ST_DIS: begin
          // Valid input or leaving the disable range opens a new cycle
          start_cyc = 1'b1; // [RULE7] [RULE16]
          next_stat = 1'b1; // [RULE16]
          next_state = cycle_entry(flags[`CMSC_F_ABOVE_PRE]);
        end
        ST_PRE: begin
          if (flags[`CMSC_F_ABOVE_PRE]) begin
            next_state = ST_FAST;
          end
        end
        ST_FAST: begin
          if (term_done) begin
            term_evt = 1'b1; // [RULE23]
            if (mode_eff == `CMSC_MODE_LOW) begin
              next_state = ST_FLOAT; // [RULE1] [RULE14]
            end else begin
              next_state = ST_MON; // [RULE2] [RULE8]
            end
          end
        end
        ST_FLOAT: begin
          // Forced float charging ends only at a fresh termination
          if (mode_eff == `CMSC_MODE_MID && term_done) begin
            next_state = ST_MON; // [RULE11] [RULE13]
          end
        end
        ST_MON: begin
          if (mode_eff == `CMSC_MODE_LOW) begin
            next_state = ST_FLOAT; // [RULE10] [RULE13]
          end else if (flags[`CMSC_F_BELOW_RECH]) begin
            next_state = cycle_entry(flags[`CMSC_F_ABOVE_PRE]); // [RULE9] [RULE19]
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
      // Release after termination waits out the full-battery hold
      if ((term_pending || term_evt) && hold_cnt == {CNT_W{1'b0}} && !start_cyc) begin
        next_stat = 1'b0; // [RULE17] [RULE18]
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      stat_on <= 1'b0;
      mode_hold_high <= 1'b0;
      term_pending <= 1'b0;
      hold_cnt <= {CNT_W{1'b0}};
    end else begin
      state <= next_state;
      stat_on <= next_stat;
      if (flags[`CMSC_F_ABOVE_HIGH]) begin
        mode_hold_high <= 1'b1; // [RULE4]
      end else begin
        mode_hold_high <= 1'b0; // [RULE5]
      end
      if (start_cyc) begin
        hold_cnt <= FULL_HOLD - 1'b1; // [RULE18]
      end else if (hold_cnt != {CNT_W{1'b0}}) begin
        hold_cnt <= hold_cnt - 1'b1;
      end
      if (start_cyc || !next_stat) begin
        term_pending <= 1'b0;
      end else if (term_evt) begin
        term_pending <= 1'b1;
      end
    end
  end

  // Regulation mode and soft-start; thermal limiting touches neither
  always @(posedge aclk) begin
    if (!aresetn) begin
      cv_regulation <= 1'b0;
      current_level <= `CMSC_LVL_PRE;
      step_cnt <= {CNT_W{1'b0}};
    end else if (next_state == ST_FAST || next_state == ST_FLOAT) begin // [RULE26]
      if (!cv_regulation && flags[`CMSC_F_ABOVE_TRANS]) begin
        cv_regulation <= 1'b1; // [RULE20] [RULE21]
      end else if (cv_regulation && flags[`CMSC_F_OVER_CURR]) begin
        cv_regulation <= 1'b0; // [RULE22]
      end
      if (state != ST_FAST && state != ST_FLOAT) begin
        current_level <= `CMSC_LVL_20; // [RULE24]
        step_cnt <= {CNT_W{1'b0}};
      end else if (current_level != `CMSC_LVL_100) begin
        if (step_cnt >= SOFT_STEP - 1'b1) begin
          step_cnt <= {CNT_W{1'b0}};
          current_level <= current_level + 1'b1; // [RULE24]
        end else begin
          step_cnt <= step_cnt + 1'b1;
        end
      end
    end else begin
      cv_regulation <= 1'b0;
      current_level <= `CMSC_LVL_PRE;
      step_cnt <= {CNT_W{1'b0}};
    end
  end

  // Pin-facing outputs, all registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      charge_output_en <= 1'b0;
      mode_float_en <= 1'b1;
      mode_input_hiz <= 1'b0;
      charge_status_n_o <= 1'b0;
      charge_status_n_oe_n <= 1'b1;
    end else begin
      charge_output_en <= (next_state == ST_PRE) || (next_state == ST_FAST) ||
                          (next_state == ST_FLOAT); // [RULE1] [RULE2] [RULE10]
      mode_float_en <= !flags[`CMSC_F_ABOVE_HIGH]; // [RULE4]
      mode_input_hiz <= flags[`CMSC_F_ABOVE_HIGH]; // [RULE4]
      // Data stays low so the pin can only sink, never source
      charge_status_n_o <= 1'b0; // [RULE15]
      charge_status_n_oe_n <= !next_stat; // [RULE15]
    end
  end

  // AXI4-Lite slave: one write and one read in flight
  reg aw_have;
  reg w_have;
  reg [ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire b_done = s_axi_bvalid && s_axi_bready;
  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire next_aw_have = (aw_have || aw_take) && !b_done;
  wire next_w_have = (w_have || w_take) && !b_done;
  wire next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
  wire [31:0] status_word = {20'h00000, flags[`CMSC_F_THERMAL], input_ok, term_pending,
                             stat_on, cv_regulation, current_level, mode_eff, state};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMSC_RESP_OKAY;
      ctrl_en <= `CMSC_CTRL_RESET;
    end else begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= !next_aw_have && !next_bvalid;
      s_axi_wready <= !next_w_have && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_write) begin
        if (aw_addr == `CMSC_REG_CTRL) begin
          s_axi_bresp <= `CMSC_RESP_OKAY;
          if (w_strb[0]) begin
            ctrl_en <= w_data[`CMSC_CTRL_EN_BIT];
          end
        end else if (aw_addr == `CMSC_REG_STATUS) begin
          // Status is read-only; writes are accepted and dropped
          s_axi_bresp <= `CMSC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `CMSC_RESP_SLVERR;
        end
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CMSC_RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        if (s_axi_araddr == `CMSC_REG_CTRL) begin
          s_axi_rdata <= {31'h00000000, ctrl_en};
          s_axi_rresp <= `CMSC_RESP_OKAY;
        end else if (s_axi_araddr == `CMSC_REG_STATUS) begin
          s_axi_rdata <= status_word;
          s_axi_rresp <= `CMSC_RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `CMSC_RESP_SLVERR;
        end
      end
    end
  end
endmodule

/* verif/cmsc_assertions.sv */
module cmsc_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mode_above_high,
  input wire logic input_uvlo_ok,
  input wire logic input_ovp,
  input wire logic vout_above_transition,
  input wire logic iout_over_margin,
  input wire logic charge_output_en,
  input wire logic cv_regulation,
  input wire logic [1:0] current_level,
  input wire logic mode_float_en,
  input wire logic mode_input_hiz,
  input wire logic charge_status_n_o,
  input wire logic charge_status_n_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Five samples cover the two sync flops plus the output flop
  sequence s_high_held;
    mode_above_high [*5];
  endsequence
  sequence s_supply_up;
    !input_uvlo_ok ##1 (input_uvlo_ok && !input_ovp && !mode_above_high) [*4];
  endsequence
  a_open_drain:
    assert property (!charge_status_n_oe_n |-> !charge_status_n_o) else $error("status driven high");
  a_high_disables:
    assert property (s_high_held |=> !charge_output_en && charge_status_n_oe_n && !mode_float_en)
    else $error("high selection did not disable");
  a_hiz_float:
    assert property (mode_input_hiz == !mode_float_en) else $error("hiz and float disagree");
  a_supply_start:
    assert property (s_supply_up |=> charge_output_en && !charge_status_n_oe_n)
    else $error("no cycle start on valid input");
  a_ovp_halts:
    assert property (input_ovp [*5] |=> !charge_output_en && charge_status_n_oe_n)
    else $error("overvoltage did not halt");
  a_no_input_idle:
    assert property (!input_uvlo_ok [*5] |=> !charge_output_en && charge_status_n_oe_n)
    else $error("no input but not idle");
  a_cv_cause:
    assert property ($rose(cv_regulation) |-> $past(vout_above_transition, 3)
      || $past(vout_above_transition, 4)) else $error("cv without transition");
  a_cv_reverts:
    assert property ((iout_over_margin && !vout_above_transition) [*5] |=> !cv_regulation)
    else $error("cv kept despite over current");
  a_soft_steps:
    assert property ($changed(current_level) && current_level[1]
      |-> $past(current_level) == current_level - 2'd1) else $error("soft start step skipped");
endmodule

bind cmsc_top cmsc_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .mode_above_high(mode_above_high), .input_uvlo_ok(input_uvlo_ok), .input_ovp(input_ovp),
  .vout_above_transition(vout_above_transition), .iout_over_margin(iout_over_margin),
  .charge_output_en(charge_output_en), .cv_regulation(cv_regulation),
  .current_level(current_level), .mode_float_en(mode_float_en),
  .mode_input_hiz(mode_input_hiz), .charge_status_n_o(charge_status_n_o),
  .charge_status_n_oe_n(charge_status_n_oe_n));

/* verif/cmsc_host_model.sv */
module cmsc_host_model (
  input wire logic gpio_oe,
  input wire logic gpio_val,
  input wire logic mode_float_en,
  input wire logic charge_status_n_o,
  input wire logic charge_status_n_oe_n,
  output logic mode_below_low,
  output logic mode_above_high,
  output logic status_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  assign mode_below_low = gpio_oe && !gpio_val;
  // Float circuit off: a released pin is not pulled back to mid, so it still reads high
  assign mode_above_high = gpio_oe ? gpio_val : !mode_float_en;
  // Pull-up on the released line; interrupt is the pulled-low level
  assign status_irq = charge_status_n_oe_n ? 1'b0 : !charge_status_n_o;
endmodule

/* verif/tb_charge_mode_status_control.sv */
module tb_charge_mode_status_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TW = 8;
  localparam int FH = 20;
  localparam int SS = 4;
  localparam int LAT = 4;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0;
  wire awr, wr, bv, arr, rv;
  wire [1:0] br, rr, lvl;
  wire [31:0] rd;
  logic uvlo = 1'b0, ovp = 1'b0, pre = 1'b0, rech = 1'b0, trans = 1'b0;
  logic over = 1'b0, term = 1'b0, therm = 1'b0, gpio_oe = 1'b0, gpio_val = 1'b0;
  wire below, above, out_en, cv, float_en, hiz, st_o, st_oe_n, irq;
  int error_cnt = 0;
  int total_checks = 0;

  cmsc_top #(.TERM_WIN_CYCLES(TW), .FULL_HOLD_CYCLES(FH), .SOFT_STEP_CYCLES(SS)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .mode_below_low(below), .mode_above_high(above),
    .input_uvlo_ok(uvlo), .input_ovp(ovp), .bat_above_precharge(pre),
    .bat_below_recharge(rech), .vout_above_transition(trans), .iout_over_margin(over),
    .iout_below_term(term), .thermal_limit(therm), .charge_output_en(out_en),
    .cv_regulation(cv), .current_level(lvl), .mode_float_en(float_en),
    .mode_input_hiz(hiz), .charge_status_n_o(st_o), .charge_status_n_oe_n(st_oe_n));

  cmsc_host_model host (.gpio_oe(gpio_oe), .gpio_val(gpio_val), .mode_float_en(float_en),
    .charge_status_n_o(st_o), .charge_status_n_oe_n(st_oe_n), .mode_below_low(below),
    .mode_above_high(above), .status_irq(irq));

  initial begin
    forever #25 aclk = ~aclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Output enable and status interrupt seen by the host
  task automatic st(input logic en, input logic asserted);
    chk({30'h0, out_en, irq}, {30'h0, en, asserted});
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bry <= 1'b1;
    // Only the watchdog bounds this wait
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    bry <= 1'b0;
    chk({30'h0, br}, {30'h0, er});
  endtask

  task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rry <= 1'b0;
    chk(rd, ed);
    chk({30'h0, rr}, {30'h0, er});
  endtask

  task automatic t_reset;
    tick(LAT);
    st(1'b0, 1'b0);
    chk({30'h0, float_en, hiz}, 32'h2);
    axr(4'h0, 32'h1, 2'b00);
    // Status is read-only: the write is answered but leaves it alone
    axw(4'h4, 32'hFFF, 2'b00);
    axr(4'h4, 32'h8, 2'b00);
    axw(4'h8, 32'h0, 2'b10);
    axr(4'h8, 32'h0, 2'b10);
  endtask

  task automatic t_full;
    @(posedge aclk);
    gpio_oe <= 1'b1;
    uvlo <= 1'b1;
    pre <= 1'b1;
    term <= 1'b1;
    tick(LAT);
    st(1'b1, 1'b1);
    tick(TW + LAT);
    st(1'b1, 1'b1);
    tick(FH);
    st(1'b1, 1'b0);
    @(posedge aclk);
    trans <= 1'b1;
    tick(LAT);
    chk({31'h0, cv}, 32'h1);
    @(posedge aclk);
    trans <= 1'b0;
    over <= 1'b1;
    tick(LAT);
    chk({31'h0, cv}, 32'h0);
  endtask

  task automatic t_high;
    @(posedge aclk);
    over <= 1'b0;
    gpio_val <= 1'b1;
    tick(LAT);
    st(1'b0, 1'b0);
    chk({30'h0, float_en, hiz}, 32'h1);
    @(posedge aclk);
    gpio_oe <= 1'b0;
    term <= 1'b0;
    tick(LAT);
    st(1'b0, 1'b0);
    @(posedge aclk);
    gpio_oe <= 1'b1;
    gpio_val <= 1'b0;
    tick(LAT);
    st(1'b1, 1'b1);
    @(posedge aclk);
    gpio_oe <= 1'b0;
    tick(3 * SS + LAT);
    chk({30'h0, lvl}, 32'h3);
  endtask

  task automatic t_monitor;
    @(posedge aclk);
    term <= 1'b1;
    tick(TW + FH);
    st(1'b0, 1'b0);
    @(posedge aclk);
    term <= 1'b0;
    rech <= 1'b1;
    tick(LAT);
    st(1'b1, 1'b0);
    @(posedge aclk);
    rech <= 1'b0;
    term <= 1'b1;
    tick(TW + FH);
    st(1'b0, 1'b0);
  endtask

  task automatic t_forced;
    @(posedge aclk);
    gpio_oe <= 1'b1;
    term <= 1'b0;
    tick(LAT);
    st(1'b1, 1'b0);
    tick(40);
    @(posedge aclk);
    gpio_oe <= 1'b0;
    term <= 1'b1;
    tick(TW + FH);
    st(1'b0, 1'b0);
  endtask

  task automatic t_fault;
    @(posedge aclk);
    term <= 1'b0;
    uvlo <= 1'b0;
    tick(LAT);
    st(1'b0, 1'b0);
    @(posedge aclk);
    uvlo <= 1'b1;
    tick(LAT);
    st(1'b1, 1'b1);
    @(posedge aclk);
    gpio_oe <= 1'b1;
    therm <= 1'b1;
    tick(LAT);
    st(1'b1, 1'b1);
    @(posedge aclk);
    gpio_oe <= 1'b0;
    ovp <= 1'b1;
    tick(LAT);
    st(1'b0, 1'b0);
    // Restart on a flat battery so the precharge state is exercised too
    @(posedge aclk);
    ovp <= 1'b0;
    pre <= 1'b0;
    tick(LAT);
    st(1'b1, 1'b1);
    chk({30'h0, lvl}, 32'h0);
    @(posedge aclk);
    pre <= 1'b1;
    tick(LAT);
    chk({30'h0, lvl}, 32'h1);
  endtask

  // Software enable off forces idle, then a fresh cycle when set again
  task automatic t_ctrl;
    axw(4'h0, 32'h0, 2'b00);
    tick(2);
    st(1'b0, 1'b0);
    axr(4'h0, 32'h0, 2'b00);
    axr(4'h4, 32'h808, 2'b00);
    axw(4'h0, 32'h1, 2'b00);
    tick(2);
    st(1'b1, 1'b1);
  endtask

  task automatic conclude;
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_full();
    t_high();
    t_monitor();
    t_forced();
    t_fault();
    t_ctrl();
    conclude();
  end

  // The sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    conclude();
  end
endmodule
